/* rtl/dce_pkg.sv */
package dce_pkg;

  // ----------------------------------------------------------------
  // serial bus addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] WR_ADDR     = 8'hD4;
  localparam logic [7:0] RD_ADDR     = 8'hD5;
  localparam logic [7:0] BLOCK_CMD   = 8'h00;
  localparam logic [7:0] BLOCK_COUNT = 8'h07;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [3:0] BIT_ZERO    = 4'h0;
  localparam logic [3:0] BIT_ONE     = 4'h1;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_GRP_A   = 8'h05;
  localparam logic [7:0] IDX_GRP_B   = 8'h06;
  localparam logic [7:0] IDX_STEP    = 8'h01;
  localparam logic [7:0] GRP_RESET   = 8'hFF;
  localparam logic [7:0] RSVD_VALUE  = 8'h00;

  // pair enable positions: bit number and register (0 = group a)
  localparam int         NUM_PAIRS   = 6;
  localparam int         PAIR_BIT  [NUM_PAIRS] = '{7, 6, 3, 2, 3, 1};
  localparam bit         PAIR_IN_B [NUM_PAIRS] = '{0, 0, 0, 0, 1, 1};
  localparam logic [NUM_PAIRS-1:0] EN_RESET = 6'h3F;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ADACK = 3'b010,
    ST_WRB   = 3'b011,
    ST_WACK  = 3'b100,
    ST_RDB   = 3'b101,
    ST_RACK  = 3'b110
  } dce_state_t;

  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_CNT  = 2'b01,
    PH_DATA = 2'b10
  } dce_phase_t;

endpackage

/* rtl/dce_top.sv */
// How it works
// - write address D4 acknowledged, others ignored
// - read address D5 acknowledged, registers returned
// - block and byte write/read forms supported
// - indices zero to four reserved, no effect
// - group a bits 7,6 enable pairs 0,1
// - group a bits 3,2 enable pairs 2,3
// - group b bits 3,1 enable pairs 4,5
// - both enable registers power up all ones
// - six true/complement pairs in opposite phase
// - feedback output follows reference clock always
`timescale 1ns/1ns
module dce_top
  import dce_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ref_clk_i,
  input  wire logic                 serial_bus_clock_i,
  input  wire logic                 serial_bus_data_i,
  output logic                      serial_bus_data_o,
  output logic                      serial_bus_data_oe_n_o,
  output logic [NUM_PAIRS-1:0]      true_clock_out_o,
  output logic [NUM_PAIRS-1:0]      complement_clock_out_o,
  output logic                      feedback_clock_out_o
);

  // ----------------------------------------------------------------
  // pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  logic [1:0]      pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_p_q;
  logic [1:0]      pin_f_d;
  logic            scl_rise, scl_fall, bus_start, bus_stop;

  // a level counts only once the second and third stage agree
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_f_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s3_q[i] : pin_f_q[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      pin_f_q  <= 2'h3;
      pin_p_q  <= 2'h3;
    end else begin
      pin_s1_q <= {serial_bus_clock_i, serial_bus_data_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
      pin_p_q  <= pin_f_q;
    end
  end

  // bit 1 is the bus clock, bit 0 the bus data
  assign scl_rise  = pin_f_q[1] & ~pin_p_q[1];
  assign scl_fall  = ~pin_f_q[1] & pin_p_q[1];
  assign bus_start = pin_f_q[1] & pin_p_q[1] & pin_p_q[0] & ~pin_f_q[0];
  assign bus_stop  = pin_f_q[1] & pin_p_q[1] & ~pin_p_q[0] & pin_f_q[0];

  // ----------------------------------------------------------------
  // serial slave and register file
  // ----------------------------------------------------------------
  dce_state_t      st_q, st_d;
  dce_phase_t      phase_q, phase_d;
  logic [3:0]      bitcnt_q, bitcnt_d;
  logic [7:0]      shreg_q, shreg_d;
  logic [7:0]      idx_q, idx_d;
  logic [7:0]      grp_a_q, grp_a_d;
  logic [7:0]      grp_b_q, grp_b_d;
  logic            rw_q, rw_d;
  logic            blk_q, blk_d;
  logic            cnt_sent_q, cnt_sent_d;
  logic            sda_low_q, sda_low_d;
  logic            load_tx;

  // reserved indices read as zero; reserved bits of 5 and 6 read back
  function automatic logic [7:0] rd_byte(input logic [7:0] idx,
                                         input logic [7:0] a,
                                         input logic [7:0] b);
    return (idx == IDX_GRP_A) ? a : ((idx == IDX_GRP_B) ? b : RSVD_VALUE);
  endfunction

  // next-state logic for the whole transfer engine
  always_comb begin
    st_d       = st_q;
    phase_d    = phase_q;
    bitcnt_d   = bitcnt_q;
    shreg_d    = shreg_q;
    idx_d      = idx_q;
    grp_a_d    = grp_a_q;
    grp_b_d    = grp_b_q;
    rw_d       = rw_q;
    blk_d      = blk_q;
    cnt_sent_d = cnt_sent_q;
    sda_low_d  = sda_low_q;
    load_tx    = 1'b0;
    if (bus_stop) begin
      st_d      = ST_IDLE;
      sda_low_d = 1'b0;
    end else if (bus_start) begin
      // repeated start keeps index and mode for the read part
      st_d      = ST_ADDR;
      bitcnt_d  = BIT_ZERO;
      sda_low_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_low_d = 1'b0;
        end
        ST_ADDR, ST_WRB: begin
          if (scl_rise && bitcnt_q != BYTE_BITS) begin
            shreg_d  = {shreg_q[6:0], pin_f_q[0]};
            bitcnt_d = bitcnt_q + BIT_ONE;
          end else if (scl_fall && bitcnt_q == BYTE_BITS) begin
            if (st_q == ST_ADDR) begin
              if (shreg_q == WR_ADDR || shreg_q == RD_ADDR) begin
                st_d       = ST_ADACK;
                sda_low_d  = 1'b1;
                rw_d       = shreg_q[0];
                phase_d    = PH_CMD;
                cnt_sent_d = 1'b0;
              end else begin
                st_d = ST_IDLE;
              end
            end else begin
              st_d      = ST_WACK;
              sda_low_d = 1'b1;
              case (phase_q)
                PH_CMD: begin
                  idx_d   = shreg_q;
                  blk_d   = (shreg_q == BLOCK_CMD);
                  phase_d = (shreg_q == BLOCK_CMD) ? PH_CNT : PH_DATA;
                end
                PH_CNT: begin
                  phase_d = PH_DATA;
                end
                default: begin
                  // writes below index five change nothing
                  if (idx_q == IDX_GRP_A) begin
                    grp_a_d = shreg_q;
                  end else if (idx_q == IDX_GRP_B) begin
                    grp_b_d = shreg_q;
                  end
                  idx_d = idx_q + IDX_STEP;
                end
              endcase
            end
          end
        end
        ST_ADACK, ST_WACK: begin
          if (scl_fall) begin
            sda_low_d = 1'b0;
            bitcnt_d  = BIT_ZERO;
            if (st_q == ST_ADACK && rw_q) begin
              st_d    = ST_RDB;
              load_tx = 1'b1;
            end else begin
              st_d = ST_WRB;
            end
          end
        end
        ST_RDB: begin
          if (scl_fall) begin
            if (bitcnt_q == LAST_BIT) begin
              st_d      = ST_RACK;
              sda_low_d = 1'b0;
            end else begin
              shreg_d   = {shreg_q[6:0], 1'b0};
              sda_low_d = ~shreg_q[6];
              bitcnt_d  = bitcnt_q + BIT_ONE;
            end
          end
        end
        ST_RACK: begin
          // a not-acknowledge ends the read; only stop or start follows
          if (scl_rise && pin_f_q[0]) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            st_d     = ST_RDB;
            bitcnt_d = BIT_ZERO;
            load_tx  = 1'b1;
          end
        end
        default: begin
          st_d      = ST_IDLE;
          sda_low_d = 1'b0;
        end
      endcase
    end
    // block read sends the byte count ahead of the data
    if (load_tx) begin
      if (blk_q && !cnt_sent_q) begin
        shreg_d    = BLOCK_COUNT;
        cnt_sent_d = 1'b1;
      end else begin
        shreg_d = rd_byte(idx_q, grp_a_q, grp_b_q);
        idx_d   = idx_q + IDX_STEP;
      end
      sda_low_d = ~shreg_d[7];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q       <= ST_IDLE;
      phase_q    <= PH_CMD;
      bitcnt_q   <= BIT_ZERO;
      shreg_q    <= RSVD_VALUE;
      idx_q      <= RSVD_VALUE;
      grp_a_q    <= GRP_RESET;
      grp_b_q    <= GRP_RESET;
      rw_q       <= 1'b0;
      blk_q      <= 1'b0;
      cnt_sent_q <= 1'b0;
      sda_low_q  <= 1'b0;
    end else begin
      st_q       <= st_d;
      phase_q    <= phase_d;
      bitcnt_q   <= bitcnt_d;
      shreg_q    <= shreg_d;
      idx_q      <= idx_d;
      grp_a_q    <= grp_a_d;
      grp_b_q    <= grp_b_d;
      rw_q       <= rw_d;
      blk_q      <= blk_d;
      cnt_sent_q <= cnt_sent_d;
      sda_low_q  <= sda_low_d;
    end
  end

  // open drain: only ever pulls low
  assign serial_bus_data_o      = 1'b0;
  assign serial_bus_data_oe_n_o = ~sda_low_q;

  // ----------------------------------------------------------------
  // enable map and reference clock domain
  // ----------------------------------------------------------------
  logic [NUM_PAIRS-1:0] en_vec;
  logic [NUM_PAIRS-1:0] en_s1_q, en_s2_q;

  generate
    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_map
      assign en_vec[g] = PAIR_IN_B[g] ? grp_b_q[PAIR_BIT[g]]
                                      : grp_a_q[PAIR_BIT[g]];
    end
  endgenerate

  // sampled on the falling edge so the gate only changes while low
  always_ff @(negedge ref_clk_i) begin
    if (!nrst_i) begin
      en_s1_q <= EN_RESET;
      en_s2_q <= EN_RESET;
    end else begin
      en_s1_q <= en_vec;
      en_s2_q <= en_s1_q;
    end
  end

  // gated copies of the reference; disabled pair rests true low
  assign true_clock_out_o       = {NUM_PAIRS{ref_clk_i}} & en_s2_q;
  assign complement_clock_out_o = ~true_clock_out_o;
  assign feedback_clock_out_o   = ref_clk_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_wr_addr_ack;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_ADDR && scl_fall && bitcnt_q == BYTE_BITS && shreg_q == WR_ADDR
     && !bus_start && !bus_stop) |=> (sda_low_q && !rw_q && st_q == ST_ADACK);
  endproperty
  a_wr_addr_ack: assert property (p_wr_addr_ack) else $error("write address not acked");

  property p_bad_addr;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_ADDR && scl_fall && bitcnt_q == BYTE_BITS && shreg_q != WR_ADDR
     && shreg_q != RD_ADDR && !bus_start && !bus_stop) |=> (st_q == ST_IDLE && !sda_low_q);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("foreign address answered");

  property p_rd_addr;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_ADACK && rw_q && scl_fall && !bus_start && !bus_stop)
      |=> (st_q == ST_RDB && sda_low_q == !shreg_q[7] && bitcnt_q == BIT_ZERO);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read did not start");

  property p_blk_cmd;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_WRB && phase_q == PH_CMD && scl_fall && bitcnt_q == BYTE_BITS
     && !bus_start && !bus_stop) |=> (idx_q == $past(shreg_q) && blk_q == (idx_q == BLOCK_CMD));
  endproperty
  a_blk_cmd: assert property (p_blk_cmd) else $error("block mode decode wrong");

  property p_rsvd_write;
    @(posedge clk_i) disable iff (!nrst_i)
    (idx_q < IDX_GRP_A) |=> ($stable(grp_a_q) && $stable(grp_b_q));
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) else $error("reserved index changed");

  property p_grp_write;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_q == ST_WRB && phase_q == PH_DATA && idx_q == IDX_GRP_A && scl_fall
     && bitcnt_q == BYTE_BITS && !bus_start && !bus_stop) |=> (grp_a_q == $past(shreg_q));
  endproperty
  a_grp_write: assert property (p_grp_write) else $error("group a write lost");

  property p_reset_val;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (grp_a_q == GRP_RESET && grp_b_q == GRP_RESET);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("power-up value wrong");

  property p_en_follow;
    @(negedge ref_clk_i) disable iff (!nrst_i)
    (en_vec == $past(en_vec) && $past(en_vec) == $past(en_vec, 2)) |-> (en_s2_q == en_vec);
  endproperty
  a_en_follow: assert property (p_en_follow) else $error("enable did not reach pair");

  property p_pair_out;
    @(negedge ref_clk_i) disable iff (!nrst_i)
    (true_clock_out_o == en_s2_q) && (complement_clock_out_o == ~en_s2_q);
  endproperty
  a_pair_out: assert property (p_pair_out) else $error("pair gating wrong");

  property p_feedback;
    @(edge ref_clk_i) disable iff (!nrst_i)
    feedback_clock_out_o != $past(feedback_clock_out_o);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback not toggling");

endmodule

/* test/dce_host.sv */
`timescale 1ns/1ns
module dce_host
  import dce_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ----------------------------------------------------------------
  // two-wire bus host
  // ----------------------------------------------------------------
  // both lines start released; the pull-up makes them high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // 12-cycle quarter keeps pin edges far above the 6-cycle spacing
  task automatic quarter();
    repeat (12) @(posedge clk_i);
    #1;
  endtask

  // start from idle, or repeated start from a low clock
  task automatic start();
    sda_o = 1'b1;
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_o = 1'b0;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask

  task automatic stop();
    sda_o = 1'b0;
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_o = 1'b1;
    quarter();
  endtask

  // data changes only while the clock is low
  task automatic xfer_bit(input logic b, output logic r);
    sda_o = b;
    quarter();
    scl_o = 1'b1;
    quarter();
    r = sda_i;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  // last byte is refused with a high bit to end the read
  task automatic read_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, d[i]);
    end
    xfer_bit(last, r);
  endtask

  task automatic address(input logic rd, output logic ack);
    write_byte(rd ? RD_ADDR : WR_ADDR, ack);
  endtask
endmodule

/* test/test_ddr_clock_output_enable_regs.sv */
`timescale 1ns/1ns
module test_ddr_clock_output_enable_regs
  import dce_pkg::*;
;
  logic                 clk_i;
  logic                 nrst_i;
  logic                 ref_clk;
  logic                 scl;
  logic                 host_sda;
  logic                 dev_sda;
  logic                 dev_oe_n;
  logic [NUM_PAIRS-1:0] true_o;
  logic [NUM_PAIRS-1:0] comp_o;
  logic                 fb_o;
  wire                  sda_wire;
  int                   mismatches = 0;
  int                   tests_run = 0;
  int                   cycles = 0;

  // wired-and with pull-up: low when either party pulls
  assign sda_wire = host_sda & (dev_oe_n | dev_sda);

  dce_top uut (
    .clk_i                  (clk_i),
    .nrst_i                 (nrst_i),
    .ref_clk_i              (ref_clk),
    .serial_bus_clock_i     (scl),
    .serial_bus_data_i      (sda_wire),
    .serial_bus_data_o      (dev_sda),
    .serial_bus_data_oe_n_o (dev_oe_n),
    .true_clock_out_o       (true_o),
    .complement_clock_out_o (comp_o),
    .feedback_clock_out_o   (fb_o)
  );

  dce_host host (
    .clk_i (clk_i),
    .sda_i (sda_wire),
    .scl_o (scl),
    .sda_o (host_sda)
  );

  // ----------------------------------------------------------------
  // clocks and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // odd offset keeps the reference unrelated in phase
  initial begin
    ref_clk = 1'b0;
    #3;
    forever #80 ref_clk = ~ref_clk;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] d);
    logic a;
    host.write_byte(d, a);
    check("ack", {7'h00, a}, 8'h01);
  endtask

  task automatic recv(input string what, input logic [7:0] exp, input logic last);
    logic [7:0] d;
    host.read_byte(d, last);
    check(what, d, exp);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    host.start();
    send(WR_ADDR);
    send(idx);
    send(d);
    host.stop();
  endtask

  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    host.start();
    send(WR_ADDR);
    send(idx);
    host.start();
    send(RD_ADDR);
    recv("reg", exp, 1'b1);
    host.stop();
  endtask

  // enables settle within 2 ref falls; wait 4 periods, then probe both halves
  task automatic check_pairs(input logic [5:0] en);
    repeat (4) @(posedge ref_clk);
    #30;
    check("true hi", {2'b00, true_o}, {2'b00, en});
    check("comp hi", {2'b00, comp_o}, {2'b00, ~en});
    check("fb hi", {7'h00, fb_o}, 8'h01);
    @(negedge ref_clk);
    #30;
    check("true lo", {2'b00, true_o}, 8'h00);
    check("comp lo", {2'b00, comp_o}, 8'h3F);
    check("fb lo", {7'h00, fb_o}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_reg(IDX_GRP_A, 8'hFF);
    rd_reg(IDX_GRP_B, 8'hFF);
    check_pairs(6'h3F);
  endtask

  // reserved bits written zero must read back zero
  task automatic t_byte();
    wr_reg(IDX_GRP_A, 8'h48);
    rd_reg(IDX_GRP_A, 8'h48);
    check_pairs(6'h36);
  endtask

  task automatic t_block();
    host.start();
    send(WR_ADDR);
    send(BLOCK_CMD);
    send(BLOCK_COUNT);
    for (int i = 0; i < 5; i++) begin
      send(8'h5A);
    end
    send(8'h84);
    send(8'h08);
    host.stop();
    host.start();
    send(WR_ADDR);
    send(BLOCK_CMD);
    host.start();
    send(RD_ADDR);
    recv("count", BLOCK_COUNT, 1'b0);
    for (int i = 0; i < 5; i++) begin
      recv("reserved", 8'h00, 1'b0);
    end
    recv("grp a", 8'h84, 1'b0);
    recv("grp b", 8'h08, 1'b1);
    host.stop();
    check_pairs(6'h19);
  endtask

  // foreign address is ignored, then outputs come back on rewrite
  task automatic t_bad_addr();
    logic a;
    host.start();
    host.write_byte(8'hD6, a);
    check("bad ack", {7'h00, a}, 8'h00);
    host.stop();
    wr_reg(IDX_GRP_A, 8'hFF);
    wr_reg(IDX_GRP_B, 8'hFF);
    // bare read carries on from the index the last write left, past group b
    host.start();
    send(RD_ADDR);
    recv("bare", RSVD_VALUE, 1'b1);
    host.stop();
    check_pairs(6'h3F);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  // reset outlasts 2 ref periods so the ref-side flops clear too
  initial begin
    nrst_i = 1'b0;
    repeat (60) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    t_reset();
    t_byte();
    t_block();
    t_bad_addr();
    end_sim();
  end
endmodule
